//--- pkg/irqc_pkg.sv
// constants shared by the prioritized interrupt controller and its leaves
// assumes an apb slave port with 32-bit data and a single 125 mhz clock
//
// Summary of operation
// - 24 vectors: 12 pin, 12 peripheral sources
// - 8 pins pick rising/falling edge, 4 both
// - vector msb at even, lsb odd address
// - vectors two bytes apart, 0008h down to 0036h
// - uart, i2c, spi, watchdog held; others pulse
// - enable instruction, return or write one sets enable
// - disable, acknowledge, write zero, reset, traps clear
// - level 3 beats level 2 beats level 1
// - same level: earliest vector wins
// - reset, watchdog, illegal trap always top priority (here watchdog only with wdt_en_r set; illegal_trap presents no vector)
// - one-cycle source pulse captured into flag
// - acknowledge clears pulse-type flag
// - writing zero clears pulse-type flag
// - acknowledge leaves held-type flag alone
// - zero write leaves held flag set while its source is active
// - enables never alter flags; flags stay readable
// - any source request sets its flag
// - enable pair: 00 off, 01/10/11 levels 1-3
// - forward request only while master enable set
`default_nettype none

package irqc_pkg;
    localparam int          NUM_SRC        = 24;
    localparam int          NUM_PERIPH     = 12;
    localparam int          NUM_PAD        = 8;
    localparam int          NUM_PORTC      = 4;
    localparam int          IDX_W          = 5;
    // register byte offsets
    localparam logic [7:0]  OFS_REQ        = 8'h00;
    localparam logic [7:0]  OFS_ENH        = 8'h04;
    localparam logic [7:0]  OFS_ENL        = 8'h08;
    localparam logic [7:0]  OFS_CTRL       = 8'h0C;
    localparam logic [7:0]  OFS_EDGE       = 8'h10;
    localparam logic [7:0]  OFS_STAT       = 8'h14;
    // control fields
    localparam int          CTRL_MIE_BIT   = 0;
    localparam int          CTRL_WDT_BIT   = 1;
    localparam logic [23:0] REQ_RST        = 24'h000000;
    localparam logic [23:0] EN_RST         = 24'h000000;
    localparam logic [7:0]  EDGE_RST       = 8'h00;
    // sources that hold their request until cleared at the source
    localparam logic [23:0] HELD_MASK      = 24'h060078;
    // vector addresses
    localparam logic [15:0] VEC_RESET      = 16'h0002;
    localparam logic [15:0] VEC_WDT        = 16'h0004;
    localparam logic [15:0] VEC_TRAP       = 16'h0006;
    localparam logic [15:0] VEC_BASE       = 16'h0008;
    localparam logic [15:0] VEC_LAST       = 16'h0036;
    localparam logic [1:0]  LVL_OFF        = 2'h0;
    localparam logic [1:0]  LVL_TOP        = 2'h3;
endpackage : irqc_pkg

`default_nettype wire

//--- verilog/irqc_pin_edge.sv
// pin synchroniser and edge detector for the port-pin sources
// assumes asynchronous pin levels and a free running pclk
`default_nettype none

module irqc_pin_edge #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output logic      [W-1:0] pulse
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // one pulse per settled change in an enabled direction, exactly one pclk long
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign pulse[i] = (rise_en[i] & s2_r[i] & ~s3_r[i])
                            | (fall_en[i] & ~s2_r[i] & s3_r[i]);
        end
    endgenerate
endmodule : irqc_pin_edge

`default_nettype wire

//--- verilog/irqc_arbiter.sv
// combinational arbiter: highest level, then lowest source index
// assumes index 0 is the earliest vector in the fixed ordering
`default_nettype none

module irqc_arbiter
    import irqc_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] pend,
    input  wire logic [NUM_SRC-1:0] en_hi,
    input  wire logic [NUM_SRC-1:0] en_lo,
    output logic                    win_valid,
    output logic      [IDX_W-1:0]   win_idx
);
    logic [1:0] best_lvl;
    logic [1:0] lvl;

    // scan downward so that on equal level the lower index wins
    always_comb begin
        best_lvl  = LVL_OFF;
        win_idx   = '0;
        lvl       = LVL_OFF;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            lvl = {en_hi[i], en_lo[i]};
            if (pend[i] && lvl != LVL_OFF && lvl >= best_lvl) begin
                best_lvl = lvl;
                win_idx  = IDX_W'(i);
            end
        end
        win_valid = (best_lvl != LVL_OFF);
    end
endmodule : irqc_arbiter

`default_nettype wire

//--- verilog/prioritized_interrupt_controller.sv
// vectored interrupt controller with apb register access
// assumes the core pulses its instruction strobes and irq_ack for one pclk
`default_nettype none

module prioritized_interrupt_controller
    import irqc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NUM_PERIPH-1:0] periph_irq,
    input  wire logic [NUM_PAD-1:0]    pad_pin,
    input  wire logic [NUM_PORTC-1:0]  portc_pin,
    input  wire logic                  wdt_irq,
    input  wire logic                  enable_irq_instruction,
    input  wire logic                  disable_irq_instruction,
    input  wire logic                  return_from_irq_instruction,
    input  wire logic                  trap_exec,
    input  wire logic                  illegal_trap,
    input  wire logic                  irq_ack,
    output logic                       irq_req,
    output logic      [15:0]           irq_vector,
    output logic                       master_irq_enable
);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [NUM_SRC-1:0] req_r;
    logic [NUM_SRC-1:0] req_nxt;
    logic [NUM_SRC-1:0] enh_r;
    logic [NUM_SRC-1:0] enl_r;
    logic [NUM_PAD-1:0] edge_r;
    logic               mie_r;
    logic               mie_nxt;
    logic               wdt_en_r;
    logic               irq_req_r;
    logic [15:0]        vec_r;
    logic               vec_wdt_r;
    logic [IDX_W-1:0]   vec_idx_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;

    logic [NUM_SRC-1:0]   src_set;
    logic [NUM_PAD-1:0]   pad_pulse;
    logic [NUM_PORTC-1:0] portc_pulse;
    logic                 win_valid;
    logic [IDX_W-1:0]     win_idx;
    logic                 wr_en;
    logic                 ack_take;
    logic [7:0]           addr8;
    logic                 addr_hit;

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign irq_req           = irq_req_r;
    assign irq_vector        = vec_r;
    assign master_irq_enable = mie_r;

    ////////////////////////////////////////////////////////////////////////
    // source collection

    irqc_pin_edge #(
        .W (NUM_PAD)
    ) u_pad_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pad_pin),
        .rise_en (~edge_r),
        .fall_en (edge_r),
        .pulse   (pad_pulse)
    );

    irqc_pin_edge #(
        .W (NUM_PORTC)
    ) u_portc_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (portc_pin),
        .rise_en ({NUM_PORTC{1'b1}}),
        .fall_en ({NUM_PORTC{1'b1}}),
        .pulse   (portc_pulse)
    );

    // index order follows vector order: index 0 sits at the base vector
    genvar k;
    generate
        for (k = 0; k < NUM_PAD; k++) begin : g_pad_map
            assign src_set[8 + k] = pad_pulse[NUM_PAD - 1 - k];
        end
        for (k = 0; k < NUM_PORTC; k++) begin : g_portc_map
            assign src_set[20 + k] = portc_pulse[NUM_PORTC - 1 - k];
        end
        for (k = 0; k < 8; k++) begin : g_per_lo
            assign src_set[k] = periph_irq[k];
        end
        for (k = 0; k < 4; k++) begin : g_per_hi
            assign src_set[16 + k] = periph_irq[8 + k];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, write commits on the pready edge

    assign addr8    = 8'(paddr);
    assign wr_en    = psel & penable & pready_r & pwrite;
    assign addr_hit = (addr8 == OFS_REQ)  || (addr8 == OFS_ENH)
                   || (addr8 == OFS_ENL)  || (addr8 == OFS_CTRL)
                   || (addr8 == OFS_EDGE) || (addr8 == OFS_STAT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~addr_hit;
            if (psel && penable && !pready_r && !pwrite) begin
                case (addr8)
                    OFS_REQ:  prdata_r <= {8'h00, req_r};
                    OFS_ENH:  prdata_r <= {8'h00, enh_r};
                    OFS_ENL:  prdata_r <= {8'h00, enl_r};
                    OFS_CTRL: prdata_r <= {30'h00000000, wdt_en_r, mie_r};
                    OFS_EDGE: prdata_r <= {24'h000000, edge_r};
                    OFS_STAT: prdata_r <= {irq_req_r, 10'h000, vec_idx_r,
                                           vec_r};
                    default:  prdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enh_r    <= EN_RST;
            enl_r    <= EN_RST;
            edge_r   <= EDGE_RST;
            wdt_en_r <= 1'b0;
        end else if (wr_en) begin
            if (addr8 == OFS_ENH)
                enh_r <= pwdata[NUM_SRC-1:0];
            if (addr8 == OFS_ENL)
                enl_r <= pwdata[NUM_SRC-1:0];
            if (addr8 == OFS_EDGE)
                edge_r <= pwdata[NUM_PAD-1:0];
            if (addr8 == OFS_CTRL)
                wdt_en_r <= pwdata[CTRL_WDT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request flags

    assign ack_take = irq_ack & irq_req_r;

    // enables play no part here, so polled operation sees raw flags
    always_comb begin
        req_nxt = req_r;
        if (wr_en && addr8 == OFS_REQ)
            req_nxt = req_nxt & pwdata[NUM_SRC-1:0];
        if (ack_take && !vec_wdt_r && !HELD_MASK[vec_idx_r])
            req_nxt[vec_idx_r] = 1'b0;
        req_nxt = req_nxt | src_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            req_r <= REQ_RST;
        else
            req_r <= req_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // master enable: any clear event wins over a same-cycle set

    always_comb begin
        mie_nxt = mie_r;
        if (enable_irq_instruction || return_from_irq_instruction)
            mie_nxt = 1'b1;
        if (wr_en && addr8 == OFS_CTRL)
            mie_nxt = pwdata[CTRL_MIE_BIT];
        if (disable_irq_instruction || ack_take || trap_exec
            || illegal_trap)
            mie_nxt = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mie_r <= 1'b0;
        else
            mie_r <= mie_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration and vector presentation

    irqc_arbiter u_arb (
        .pend      (req_r),
        .en_hi     (enh_r),
        .en_lo     (enl_r),
        .win_valid (win_valid),
        .win_idx   (win_idx)
    );

    // the watchdog outranks every programmed level when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req_r <= 1'b0;
            vec_r     <= VEC_RESET;
            vec_wdt_r <= 1'b0;
            vec_idx_r <= '0;
        end else begin
            irq_req_r <= mie_nxt & ~ack_take
                       & ((wdt_en_r & wdt_irq) | win_valid);
            if (wdt_en_r && wdt_irq) begin
                vec_r     <= VEC_WDT;
                vec_wdt_r <= 1'b1;
            end else if (win_valid) begin
                // low bit stays zero: msb byte at the even address
                vec_r     <= VEC_BASE + {10'h000, win_idx, 1'b0};
                vec_wdt_r <= 1'b0;
                vec_idx_r <= win_idx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_req_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_req_r |-> $past(mie_nxt))
        else $error("request raised while master enable was clear");

    chk_ack_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        ack_take |=> !mie_r && !irq_req_r)
        else $error("acknowledge did not drop master enable");

    chk_enable_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable_irq_instruction && !disable_irq_instruction && !trap_exec
         && !illegal_trap && !ack_take && !wr_en) |=> mie_r)
        else $error("enable instruction did not set master enable");

    chk_pulse_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_set[3] |=> req_r[3])
        else $error("source request was not captured");

    chk_pulse_ack: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ack_take && !vec_wdt_r && vec_idx_r == 5'd0 && !src_set[0])
        |=> !req_r[0])
        else $error("pulse flag survived acknowledge");

    chk_held_ack: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ack_take && vec_idx_r == 5'd3 && req_r[3]
         && !(wr_en && addr8 == OFS_REQ)) |=> req_r[3])
        else $error("held flag cleared by acknowledge");

    chk_zero_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && addr8 == OFS_REQ && !pwdata[7] && !src_set[7])
        |=> !req_r[7])
        else $error("zero write left pulse flag set");

    chk_held_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && addr8 == OFS_REQ && !pwdata[4] && !src_set[4])
        ##1 src_set[4] |=> req_r[4])
        else $error("held flag not set again after clear");

    chk_wdt_top: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wdt_en_r && wdt_irq) |=> vec_r == VEC_WDT)
        else $error("watchdog did not take the vector");

    chk_vec_range: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_req_r && !vec_wdt_r) |-> (vec_r >= VEC_BASE
            && vec_r <= VEC_LAST && !vec_r[0]))
        else $error("vector address outside table");

    chk_apb_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_r) |=> pready_r)
        else $error("apb slave missed its answer cycle");

    chk_return_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        (return_from_irq_instruction && !disable_irq_instruction
         && !trap_exec && !illegal_trap && !ack_take && !wr_en) |=> mie_r)
        else $error("return instruction did not set master enable");

    chk_trap_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        (disable_irq_instruction || trap_exec || illegal_trap) |=> !mie_r)
        else $error("clear event left master enable set");

    chk_vec_even: assert property (
        @(posedge pclk) disable iff (!presetn)
        !vec_r[0])
        else $error("vector address is odd");

    chk_flags_steady: assert property (
        @(posedge pclk) disable iff (!presetn)
        (src_set == '0 && !ack_take && !(wr_en && addr8 == OFS_REQ))
        |=> req_r == $past(req_r))
        else $error("request flags changed with no cause");

    chk_disabled_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((enh_r | enl_r) == '0 && !(wdt_en_r && wdt_irq)) |=> !irq_req_r)
        else $error("request raised with every source disabled");

    chk_err_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr_r |-> pready_r)
        else $error("slave error raised without ready");

    chk_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready_r |=> !pready_r)
        else $error("apb ready held longer than one cycle");

endmodule : prioritized_interrupt_controller

`default_nettype wire

//--- bench/core_model.sv
// behavioural processor core that takes vectored requests
// assumes irq_req and irq_vector are registered outputs on pclk
`default_nettype none

module core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic [3:0]  ack_delay,
    output logic             irq_ack,
    output logic      [15:0] taken_vec,
    output logic      [7:0]  taken_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        ack_r;
    logic [3:0]  wait_r;
    logic [15:0] vec_r;
    logic [7:0]  cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // acknowledge after ack_delay cycles, one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r  <= 1'b0;
            wait_r <= 4'h0;
            vec_r  <= 16'h0000;
            cnt_r  <= 8'h00;
        end else begin
            ack_r <= 1'b0;
            if (irq_req === 1'b1 && !ack_r) begin
                if (wait_r == ack_delay) begin
                    ack_r  <= 1'b1;
                    // fetch address is the even msb byte, lsb follows
                    vec_r  <= irq_vector;
                    cnt_r  <= cnt_r + 8'h01;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else begin
                wait_r <= 4'h0;
            end
        end
    end

    assign irq_ack   = ack_r;
    assign taken_vec = vec_r;
    assign taken_cnt = cnt_r;
endmodule : core_model

`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the prioritized interrupt controller
// assumes the core model answers requests; apb master is this module
`default_nettype none

module tb_top;
    import irqc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] periph_irq;
    logic [7:0]  pad_pin, taken_cnt, seen;
    logic [3:0]  portc_pin, ack_delay;
    logic [4:0]  instr;
    logic        wdt_irq, irq_ack, irq_req, master_irq_enable, err;
    logic [15:0] irq_vector, taken_vec;
    int          errors, samples_checked, cycles;

    prioritized_interrupt_controller dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq),
        .pad_pin(pad_pin), .portc_pin(portc_pin), .wdt_irq(wdt_irq),
        .enable_irq_instruction(instr[0]),
        .disable_irq_instruction(instr[1]),
        .return_from_irq_instruction(instr[2]),
        .trap_exec(instr[3]), .illegal_trap(instr[4]), .irq_ack(irq_ack),
        .irq_req(irq_req), .irq_vector(irq_vector),
        .master_irq_enable(master_irq_enable));

    core_model core (
        .pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .irq_vector(irq_vector), .ack_delay(ack_delay), .irq_ack(irq_ack),
        .taken_vec(taken_vec), .taken_cnt(taken_cnt));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is looked at mid-cycle, where it has settled
        @(negedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(negedge pclk);
            n++;
        end
        if (n == 50) begin
            errors++;
            give_verdict();
        end
        rd  = prdata;
        err = pslverr;
        // the transfer completes at this rising edge; release after it
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
    endtask : rdchk

    task automatic strobe(input int b);
        @(posedge pclk) instr <= 5'(1 << b);
        @(posedge pclk) instr <= 5'h00;
    endtask : strobe

    task automatic pulse_src(input logic [11:0] m);
        @(posedge pclk) periph_irq <= m;
        @(posedge pclk) periph_irq <= 12'h000;
        repeat (2) @(posedge pclk);
    endtask : pulse_src

    task automatic wait_take(input logic [15:0] exp);
        int n;
        n = 0;
        while (taken_cnt === seen && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n == 200) begin
            errors++;
            give_verdict();
        end
        seen = taken_cnt;
        chk("taken vector", {16'h0000, exp}, {16'h0000, taken_vec});
        chk("vector lsb", 32'h0, {31'h0, taken_vec[0]});
        repeat (2) @(posedge pclk);
    endtask : wait_take

    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        chk("enable", 32'h0, {31'h0, master_irq_enable});
        chk("irq_req", 32'h0, {31'h0, irq_req});
        chk("vector", {16'h0, VEC_RESET}, {16'h0, irq_vector});
        rdchk("req", OFS_REQ, {8'h00, REQ_RST});
        rdchk("edge", OFS_EDGE, {24'h0, EDGE_RST});
        apb(1'b1, OFS_ENH, 32'hFFFFFFFF);
        rdchk("enh", OFS_ENH, 32'h00FFFFFF);
        apb(1'b1, OFS_ENH, 32'h00000000);
        rdchk("unmapped", 8'h40, 32'h00000000);
        chk("pslverr", 32'h1, {31'h0, err});
    endtask : s_reset

    task automatic s_pulse_ack();
        apb(1'b1, OFS_ENL, 32'h00000001);
        pulse_src(12'h001);
        rdchk("req", OFS_REQ, 32'h00000001);
        chk("no forward", 32'h0, {31'h0, irq_req});
        apb(1'b1, OFS_CTRL, 32'h00000001);
        wait_take(VEC_BASE);
        chk("enable", 32'h0, {31'h0, master_irq_enable});
        rdchk("req", OFS_REQ, 32'h00000000);
    endtask : s_pulse_ack

    task automatic s_priority();
        logic [15:0] exp [4];
        exp = '{16'h000C, 16'h0028, 16'h000A, 16'h0008};
        apb(1'b1, OFS_ENH, 32'h00010006);
        apb(1'b1, OFS_ENL, 32'h00010005);
        pulse_src(12'h187);
        rdchk("polled req", OFS_REQ, 32'h00010087);
        for (int i = 0; i < 4; i++) begin
            strobe(i == 0 ? 0 : 2);
            wait_take(exp[i]);
        end
        strobe(2);
        repeat (3) @(posedge pclk);
        chk("disabled src", 32'h0, {31'h0, irq_req});
        apb(1'b1, OFS_REQ, 32'hFFFFFF7F);
        rdchk("req", OFS_REQ, 32'h00000000);
    endtask : s_priority

    task automatic s_held();
        strobe(1);
        apb(1'b1, OFS_ENH, 32'h00000008);
        apb(1'b1, OFS_ENL, 32'h00000000);
        @(posedge pclk) periph_irq <= 12'h008;
        apb(1'b1, OFS_CTRL, 32'h00000001);
        wait_take(16'h000E);
        rdchk("held after ack", OFS_REQ, 32'h00000008);
        apb(1'b1, OFS_REQ, 32'hFFFFFFF7);
        rdchk("held after zero", OFS_REQ, 32'h00000008);
        @(posedge pclk) periph_irq <= 12'h000;
        apb(1'b1, OFS_REQ, 32'hFFFFFFF7);
        rdchk("held retired", OFS_REQ, 32'h00000000);
        // source rises in the cycle right after a zero write commits
        apb(1'b1, OFS_REQ, 32'hFFFFFFEF);
        periph_irq <= 12'h010;
        rdchk("held set again", OFS_REQ, 32'h00000010);
        @(posedge pclk) periph_irq <= 12'h000;
        apb(1'b1, OFS_REQ, 32'hFFFFFFEF);
        rdchk("held cleared", OFS_REQ, 32'h00000000);
        apb(1'b1, OFS_ENH, 32'h00000000);
    endtask : s_held

    task automatic s_master_clears();
        int ev [4];
        ev = '{1, 3, 4, 9};
        foreach (ev[i]) begin
            apb(1'b1, OFS_CTRL, 32'h00000001);
            @(posedge pclk);
            chk("enable set", 32'h1, {31'h0, master_irq_enable});
            if (ev[i] == 9) apb(1'b1, OFS_CTRL, 32'h00000000);
            else strobe(ev[i]);
            repeat (2) @(posedge pclk);
            chk("enable clr", 32'h0, {31'h0, master_irq_enable});
        end
    endtask : s_master_clears

    task automatic s_watchdog();
        ack_delay <= 4'h3;
        apb(1'b1, OFS_ENH, 32'h00000004);
        apb(1'b1, OFS_ENL, 32'h00000004);
        pulse_src(12'h004);
        @(posedge pclk) wdt_irq <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h00000003);
        wait_take(VEC_WDT);
        @(posedge pclk) wdt_irq <= 1'b0;
        strobe(2);
        wait_take(16'h000C);
        ack_delay <= 4'h0;
    endtask : s_watchdog

    task automatic s_pins();
        apb(1'b1, OFS_EDGE, 32'h00000040);
        @(posedge pclk) pad_pin <= 8'hC0;
        repeat (6) @(posedge pclk);
        rdchk("pad rise", OFS_REQ, 32'h00000100);
        @(posedge pclk) pad_pin <= 8'h00;
        repeat (6) @(posedge pclk);
        rdchk("pad fall", OFS_REQ, 32'h00000300);
        apb(1'b1, OFS_REQ, 32'h00000000);
        @(posedge pclk) portc_pin <= 4'h8;
        repeat (6) @(posedge pclk);
        rdchk("portc rise", OFS_REQ, 32'h00100000);
        apb(1'b1, OFS_REQ, 32'h00000000);
        @(posedge pclk) portc_pin <= 4'h0;
        repeat (6) @(posedge pclk);
        rdchk("portc fall", OFS_REQ, 32'h00100000);
    endtask : s_pins

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; periph_irq = 12'h000;
        pad_pin = 8'h00; portc_pin = 4'h0; instr = 5'h00; wdt_irq = 1'b0;
        ack_delay = 4'h0; seen = 8'h00;
        errors = 0; samples_checked = 0; cycles = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        s_reset();
        s_pulse_ack();
        s_priority();
        s_held();
        s_master_clears();
        s_watchdog();
        s_pins();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
